/* arm_defs.vh */
// register map, unlock keys and reset values of the accelerometer register bank
`ifndef ARM_DEFS_VH
`define ARM_DEFS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ARM_A_REV 6'h00
`define ARM_A_STAT 6'h02
`define ARM_A_XL 6'h04
`define ARM_A_XH 6'h05
`define ARM_A_YL 6'h06
`define ARM_A_YH 6'h07
`define ARM_A_ZL 6'h08
`define ARM_A_ZH 6'h09
`define ARM_A_QOUT 6'h0F
`define ARM_A_TL 6'h12
`define ARM_A_TH 6'h13
`define ARM_A_OPCFG 6'h14
`define ARM_A_CNT 6'h15
`define ARM_A_EVT 6'h16
`define ARM_A_TWRT 6'h17
`define ARM_A_PTR 6'h18
`define ARM_A_UNLK 6'h1E
`define ARM_A_PEN 6'h21
`define ARM_A_WIN 6'h22
// ---------------------------------------------------------------
// unlock key sequence
// ---------------------------------------------------------------
`define ARM_KEY0 8'h00
`define ARM_KEY1 8'h50
`define ARM_KEY2 8'hA0
// ---------------------------------------------------------------
// reset values and widths
// ---------------------------------------------------------------
`define ARM_ZERO8 8'h00
`define ARM_HID_N 16
`define ARM_HID_AW 4
`define ARM_US_IDLE 2'h0
`define ARM_US_K1 2'h1
`define ARM_US_K2 2'h2
`define ARM_BYTE 8
`define ARM_ZERO6 6'h00
`define ARM_LOCK_ON 1'h1
`define ARM_LOCK_OFF 1'h0
`endif

/* arm_regbank.v */
// accelerometer host register bank with indirect hidden registers and lock
`timescale 1ns/1ps
`include "arm_defs.vh"
module arm_regbank #(
    parameter [7:0] CHIP_REVISION = 8'h11 // arbitrary value
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    output wire REG_RD_STROBE_BUF,
    input wire [7:0] DEVICE_STATUS,
    input wire [7:0] AXIS_X_LOW,
    input wire [7:0] AXIS_X_HIGH,
    input wire [7:0] AXIS_Y_LOW,
    input wire [7:0] AXIS_Y_HIGH,
    input wire [7:0] AXIS_Z_LOW,
    input wire [7:0] AXIS_Z_HIGH,
    input wire [7:0] SAMPLE_QUEUE_OUT,
    input wire [7:0] THERMAL_LOW,
    input wire [7:0] THERMAL_HIGH,
    input wire [7:0] UNREAD_SAMPLE_COUNT,
    input wire [7:0] EVENT_FLAGS,
    input wire MIRROR_LOAD,
    input wire [7:0] MIRROR_PIN_ENABLES,
    input wire [8*`ARM_HID_N-1:0] MIRROR_HIDDEN,
    output reg [7:0] OPERATING_CONFIG,
    output reg [7:0] TWO_WIRE_READ_TARGET,
    output reg [7:0] PIN_EVENT_ENABLES,
    output reg [8*`ARM_HID_N-1:0] HIDDEN_REGS,
    output reg LOCKED
);
    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // the three axis high bytes, whose read freezes the low bytes
    function is_hi_axis;
        input [5:0] a;
        begin
            is_hi_axis = (a == `ARM_A_XH) || (a == `ARM_A_YH) || (a == `ARM_A_ZH);
        end
    endfunction

    // the window reaches a hidden byte only while unlocked and in range
    function win_open;
        input lk;
        input [7:0] p;
        begin
            win_open = !lk && (p < `ARM_HID_N);
        end
    endfunction

    // write strobe of one register address
    function wr_hit;
        input wr;
        input [5:0] a;
        input [5:0] target;
        begin
            wr_hit = wr && (a == target);
        end
    endfunction

    // next step of the unlock key walk; a wrong byte starts it over
    function [1:0] key_step;
        input [1:0] s;
        input [7:0] k;
        begin
            case (s)
                `ARM_US_IDLE: begin
                    key_step = (k == `ARM_KEY0) ? `ARM_US_K1 : `ARM_US_IDLE;
                end
                `ARM_US_K1: begin
                    if (k == `ARM_KEY1) begin
                        key_step = `ARM_US_K2;
                    end else if (k == `ARM_KEY0) begin
                        key_step = `ARM_US_K1;
                    end else begin
                        key_step = `ARM_US_IDLE;
                    end
                end
                `ARM_US_K2: begin
                    key_step = `ARM_US_IDLE;
                end
                default: begin
                    key_step = `ARM_US_IDLE;
                end
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [7:0] ptr_q;
    reg [7:0] ptr_d;
    reg [1:0] ust_q;
    reg [1:0] ust_d;
    reg locked_d;
    reg [7:0] xl_q;
    reg [7:0] yl_q;
    reg [7:0] zl_q;
    reg [7:0] rd_d;
    reg [7:0] cfg_d;
    reg [7:0] twrt_d;
    reg [7:0] pen_d;
    reg [`ARM_BYTE*`ARM_HID_N-1:0] hid_d;
    wire [`ARM_HID_AW-1:0] hidx = ptr_q[`ARM_HID_AW-1:0];
    wire win_ok = win_open(LOCKED, ptr_q);
    wire wr_cfg = wr_hit(REG_WR, REG_ADDR, `ARM_A_OPCFG);
    wire wr_twrt = wr_hit(REG_WR, REG_ADDR, `ARM_A_TWRT);
    wire wr_pen = wr_hit(REG_WR, REG_ADDR, `ARM_A_PEN);
    wire wr_ptr = wr_hit(REG_WR, REG_ADDR, `ARM_A_PTR);
    wire wr_win = wr_hit(REG_WR, REG_ADDR, `ARM_A_WIN);
    wire wr_unlk = wr_hit(REG_WR, REG_ADDR, `ARM_A_UNLK);
    wire rd_hi = REG_RD && is_hi_axis(REG_ADDR);

    // buffer pop strobe for the queue logic outside
    assign REG_RD_STROBE_BUF = REG_RD && (REG_ADDR == `ARM_A_QOUT);

    // ---------------------------------------------------------------
    // read mux; reserved addresses fall to zero
    // ---------------------------------------------------------------
    always @* begin
        rd_d = `ARM_ZERO8;
        case (REG_ADDR)
            `ARM_A_REV: rd_d = CHIP_REVISION;
            `ARM_A_STAT: rd_d = DEVICE_STATUS;
            // high read shows live data, low reads show the snapshot
            `ARM_A_XL: rd_d = xl_q;
            `ARM_A_XH: rd_d = AXIS_X_HIGH;
            `ARM_A_YL: rd_d = yl_q;
            `ARM_A_YH: rd_d = AXIS_Y_HIGH;
            `ARM_A_ZL: rd_d = zl_q;
            `ARM_A_ZH: rd_d = AXIS_Z_HIGH;
            `ARM_A_QOUT: rd_d = SAMPLE_QUEUE_OUT;
            `ARM_A_TL: rd_d = THERMAL_LOW;
            `ARM_A_TH: rd_d = THERMAL_HIGH;
            `ARM_A_OPCFG: rd_d = OPERATING_CONFIG;
            `ARM_A_CNT: rd_d = UNREAD_SAMPLE_COUNT;
            `ARM_A_EVT: rd_d = EVENT_FLAGS;
            `ARM_A_TWRT: rd_d = TWO_WIRE_READ_TARGET;
            `ARM_A_PTR: rd_d = LOCKED ? `ARM_ZERO8 : ptr_q;
            `ARM_A_UNLK: rd_d = {`ARM_ZERO6, ust_q};
            `ARM_A_PEN: rd_d = PIN_EVENT_ENABLES;
            `ARM_A_WIN: begin
                if (win_ok) begin
                    rd_d = HIDDEN_REGS[hidx*`ARM_BYTE +: `ARM_BYTE];
                end
            end
            default: rd_d = `ARM_ZERO8;
        endcase
    end

    // ---------------------------------------------------------------
    // configuration next values
    // ---------------------------------------------------------------
    // writes to read-only and reserved addresses match no strobe and fall away
    always @* begin
        cfg_d = OPERATING_CONFIG;
        if (wr_cfg) begin
            cfg_d = REG_WDATA;
        end
    end

    always @* begin
        twrt_d = TWO_WIRE_READ_TARGET;
        if (wr_twrt) begin
            twrt_d = REG_WDATA;
        end
    end

    // a host write in the reload cycle lands after the mirror value
    always @* begin
        pen_d = PIN_EVENT_ENABLES;
        if (MIRROR_LOAD) begin
            pen_d = MIRROR_PIN_ENABLES;
        end
        if (wr_pen) begin
            pen_d = REG_WDATA;
        end
    end

    // ---------------------------------------------------------------
    // indirect access next values
    // ---------------------------------------------------------------
    always @* begin
        ptr_d = ptr_q;
        if (wr_ptr && !LOCKED) begin
            ptr_d = REG_WDATA;
        end
    end

    // window writes through out-of-range pointers leave every hidden byte alone
    always @* begin
        hid_d = HIDDEN_REGS;
        if (MIRROR_LOAD) begin
            hid_d = MIRROR_HIDDEN;
        end
        if (wr_win && win_ok) begin
            hid_d[hidx*`ARM_BYTE +: `ARM_BYTE] = REG_WDATA;
        end
    end

    // ---------------------------------------------------------------
    // lock next values
    // ---------------------------------------------------------------
    // no way back to locked short of reset
    always @* begin
        ust_d = ust_q;
        locked_d = LOCKED;
        if (wr_unlk) begin
            ust_d = key_step(ust_q, REG_WDATA);
            if ((ust_q == `ARM_US_K2) && (REG_WDATA == `ARM_KEY2)) begin
                locked_d = `ARM_LOCK_OFF;
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            OPERATING_CONFIG <= `ARM_ZERO8;
        end else begin
            OPERATING_CONFIG <= cfg_d;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            TWO_WIRE_READ_TARGET <= `ARM_ZERO8;
        end else begin
            TWO_WIRE_READ_TARGET <= twrt_d;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PIN_EVENT_ENABLES <= `ARM_ZERO8;
        end else begin
            PIN_EVENT_ENABLES <= pen_d;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ptr_q <= `ARM_ZERO8;
            HIDDEN_REGS <= {`ARM_HID_N{`ARM_ZERO8}};
        end else begin
            ptr_q <= ptr_d;
            HIDDEN_REGS <= hid_d;
        end
    end

    // reset comes up locked with the key walk at its start
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ust_q <= `ARM_US_IDLE;
            LOCKED <= `ARM_LOCK_ON;
        end else begin
            ust_q <= ust_d;
            LOCKED <= locked_d;
        end
    end

    // read data stands until the next read, so the host may fetch it late
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= `ARM_ZERO8;
        end else if (REG_RD) begin
            REG_RDATA <= rd_d;
        end
    end

    // ---------------------------------------------------------------
    // axis snapshot
    // ---------------------------------------------------------------
    // low bytes freeze on a high-byte read, so a pair never mixes two samples
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            xl_q <= `ARM_ZERO8;
            yl_q <= `ARM_ZERO8;
            zl_q <= `ARM_ZERO8;
        end else if (rd_hi) begin
            xl_q <= AXIS_X_LOW;
            yl_q <= AXIS_Y_LOW;
            zl_q <= AXIS_Z_LOW;
        end
    end
endmodule

/* arm_regbank_sva.sv */
// checker on the register bank ports
`timescale 1ns/1ps
module arm_regbank_sva #(
    parameter [7:0] CHIP_REVISION = 8'h11 // arbitrary value
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire REG_RD_STROBE_BUF,
    input wire [7:0] UNREAD_SAMPLE_COUNT,
    input wire [7:0] OPERATING_CONFIG,
    input wire LOCKED
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    wire named = REG_ADDR inside {6'h00, 6'h02, [6'h04:6'h09], 6'h0F, [6'h12:6'h18], 6'h1E, 6'h21, 6'h22};
    a_rev_read: assert property (REG_RD && REG_ADDR == 6'h00 |=> REG_RDATA == CHIP_REVISION)
        else $error("bad revision");
    a_count_read: assert property (REG_RD && REG_ADDR == 6'h15 |=> REG_RDATA == $past(UNREAD_SAMPLE_COUNT))
        else $error("bad count");
    a_pop_strobe: assert property (REG_RD_STROBE_BUF == (REG_RD && REG_ADDR == 6'h0F))
        else $error("bad pop");
    a_lock_blocks: assert property (LOCKED && REG_RD && REG_ADDR inside {6'h18, 6'h22} |=> REG_RDATA == 8'h00)
        else $error("locked read");
    a_cfg_write: assert property (REG_WR && REG_ADDR == 6'h14 |=> OPERATING_CONFIG == $past(REG_WDATA))
        else $error("bad config");
    a_cfg_kept: assert property (!(REG_WR && REG_ADDR == 6'h14) |=> $stable(OPERATING_CONFIG))
        else $error("config moved");
    a_resv_zero: assert property (REG_RD && !named |=> REG_RDATA == 8'h00)
        else $error("reserved nonzero");
    a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved");
    cover property (REG_RD && REG_ADDR == 6'h0F);
    cover property ($fell(LOCKED));
    cover property (LOCKED && REG_WR && REG_ADDR == 6'h22);
endmodule
bind arm_regbank arm_regbank_sva #(.CHIP_REVISION(CHIP_REVISION)) chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RD_STROBE_BUF(REG_RD_STROBE_BUF), .UNREAD_SAMPLE_COUNT(UNREAD_SAMPLE_COUNT),
    .OPERATING_CONFIG(OPERATING_CONFIG), .LOCKED(LOCKED));

/* arm_host_model.sv */
// host model issuing single-cycle register accesses
`timescale 1ns/1ps
module arm_host_model (
    input wire SYS_CLK,
    output reg [5:0] REG_ADDR = 6'h00,
    output reg [7:0] REG_WDATA = 8'h00,
    output reg REG_WR = 1'h0,
    output reg REG_RD = 1'h0
);
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        #1;
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
        @(posedge SYS_CLK);
        #1;
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {2'b00, ~a, ~d}; // idle bus shows no stale value
    endtask
    task automatic unlock();
        access(1'b1, 6'h1E, 8'h00);
        access(1'b1, 6'h1E, 8'h50);
        access(1'b1, 6'h1E, 8'hA0);
    endtask
endmodule

/* arm_regbank_tb.sv */
// self-checking testbench for the register bank
`timescale 1ns/1ps
module arm_regbank_tb;
    logic clk = 1'b0, rst = 1'b1, ld = 1'b0;
    logic [7:0] lv [0:12], d, e, f;
    logic [5:0] resv [0:6] = '{6'h01, 6'h03, 6'h0A, 6'h10, 6'h1F, 6'h23, 6'h3F};
    logic [127:0] mh = '0;
    logic [7:0] q [$];
    wire [5:0] a;
    wire [7:0] wd, rdat, cfg, tgt, pen;
    wire wr, rd, pop, lk;
    wire [127:0] hid;
    integer miscompares = 0, checks_done = 0;
    always #50 clk = ~clk;
    arm_host_model host (.SYS_CLK(clk), .REG_ADDR(a), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd));
    arm_regbank #(.CHIP_REVISION(8'h3C)) uut (.SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(a), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .REG_RD_STROBE_BUF(pop), .DEVICE_STATUS(lv[0]),
        .AXIS_X_LOW(lv[1]), .AXIS_X_HIGH(lv[2]), .AXIS_Y_LOW(lv[3]), .AXIS_Y_HIGH(lv[4]), .AXIS_Z_LOW(lv[5]),
        .AXIS_Z_HIGH(lv[6]), .SAMPLE_QUEUE_OUT(lv[7]), .THERMAL_LOW(lv[8]), .THERMAL_HIGH(lv[9]),
        .UNREAD_SAMPLE_COUNT(lv[10]), .EVENT_FLAGS(lv[11]), .MIRROR_LOAD(ld), .MIRROR_PIN_ENABLES(lv[12]),
        .MIRROR_HIDDEN(mh), .OPERATING_CONFIG(cfg), .TWO_WIRE_READ_TARGET(tgt), .PIN_EVENT_ENABLES(pen),
        .HIDDEN_REGS(hid), .LOCKED(lk));
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
        checks_done++;
        if (s !== x) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic rdx(input logic [5:0] ad, input logic [7:0] x);
        q.push_back(x);
        host.access(1'b0, ad, 8'h00);
    endtask
    task automatic shake(input logic load);
        @(posedge clk);
        #1;
        foreach (lv[i]) lv[i] = 8'($urandom);
        mh = {$urandom, $urandom, $urandom, $urandom};
        ld = load;
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // read data lands on the edge that samples the read and is checked 5 ns later
    always @(posedge clk) begin
        if (rd === 1'b1) begin
            chk("pop", {7'h00, a == 6'h0F}, {7'h00, pop});
            #5;
            if (q.size() == 0) chk("queue", 8'h00, 8'hFF);
            else chk("rdata", q.pop_front(), rdat);
        end
    end
    initial begin
        #1000000;
        miscompares++;
        print_verdict();
    end
    initial begin
        foreach (lv[i]) lv[i] = 8'h00;
        void'($urandom(32'h564956cf));
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        chk("locked", 8'h01, {7'h00, lk});
        shake(1'b0);
        rdx(6'h00, 8'h3C);
        rdx(6'h0F, lv[7]);
        rdx(6'h12, lv[8]);
        rdx(6'h13, lv[9]);
        rdx(6'h15, lv[10]);
        rdx(6'h16, lv[11]);
        foreach (resv[i]) rdx(resv[i], 8'h00);
        host.access(1'b1, 6'h00, 8'hFF);
        rdx(6'h00, 8'h3C);
        d = 8'($urandom);
        host.access(1'b1, 6'h14, d);
        host.access(1'b1, 6'h17, ~d);
        rdx(6'h14, d);
        rdx(6'h17, ~d);
        chk("config", d, cfg);
        chk("target", ~d, tgt);
        host.access(1'b1, 6'h18, 8'h05);
        host.access(1'b1, 6'h22, d);
        rdx(6'h22, 8'h00);
        rdx(6'h18, 8'h00);
        chk("hidden", 8'h00, hid[40 +: 8]);
        host.unlock();
        chk("locked", 8'h00, {7'h00, lk});
        host.access(1'b1, 6'h18, 8'h05);
        host.access(1'b1, 6'h22, d);
        rdx(6'h22, d);
        chk("hidden", d, hid[40 +: 8]);
        shake(1'h1);
        // keep the reload values before the next shake replaces them
        e = lv[12];
        f = mh[87:80];
        shake(1'h0);
        rdx(6'h02, lv[0]);
        host.access(1'h1, 6'h18, 8'h0A);
        rdx(6'h21, e);
        chk("enables", e, pen);
        rdx(6'h22, f);
        chk("mirror", f, hid[87:80]);
        host.access(1'b1, 6'h21, d);
        chk("enables", d, pen);
        rdx(6'h05, lv[2]);
        e = lv[3];
        d = lv[1];
        shake(1'b0);
        rdx(6'h04, d);
        rdx(6'h06, e);
        host.access(1'h1, 6'h18, 8'h1F);
        rdx(6'h22, 8'h00);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule
